// ---- hw/fbep_pkg.sv ----
// Constants and types of the flash erase and protection controller.
// Assumes a word-wide synchronous flash array with one-cycle read latency.
package fbep_pkg;

	localparam int unsigned FLASH_BYTES = 96 * 1024;
	localparam int unsigned BLOCK_BYTES = 1024;
	localparam int unsigned REGION_BYTES = 2 * BLOCK_BYTES;
	localparam int unsigned NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
	localparam int unsigned NUM_REGIONS = FLASH_BYTES / REGION_BYTES;
	localparam int unsigned WORD_BYTES = 4;
	localparam int unsigned WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;

	localparam int unsigned ADDR_W = 17;
	localparam int unsigned WADDR_W = ADDR_W - 2;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BLOCK_W = 7;
	localparam int unsigned REGION_W = 6;
	localparam int unsigned WCNT_W = 8;

	// Field positions inside a byte address
	localparam int unsigned BLOCK_LSB = 10;
	localparam int unsigned REGION_LSB = 11;
	localparam int unsigned WORD_LSB = 2;

	localparam logic [ADDR_W-1:0] FLASH_LIMIT = 17'h18000;
	localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
	localparam logic [WCNT_W-1:0] WCNT_LAST = 8'hFF;
	localparam logic [WCNT_W-1:0] WCNT_RESET = 8'h00;

	typedef enum logic [1:0] {
		PROT_OPEN = 2'h0,
		PROT_READ_ONLY = 2'h1,
		PROT_EXEC_ONLY = 2'h2,
		PROT_RESERVED = 2'h3
	} fbep_prot_t;

	localparam fbep_prot_t PROT_RESET = PROT_OPEN;

	typedef enum logic [1:0] {
		KIND_FETCH = 2'h0,
		KIND_READ = 2'h1,
		KIND_PROGRAM = 2'h2,
		KIND_ERASE = 2'h3
	} fbep_kind_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RWAIT = 2'h1,
		ST_RCAP = 2'h2,
		ST_ERASE = 2'h3
	} fbep_state_t;

endpackage : fbep_pkg

// ---- hw/fbep_prot_if.sv ----
// Link between the controller and its protection table.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface fbep_prot_if;
	logic set_valid;
	logic [fbep_pkg::REGION_W-1:0] set_region;
	fbep_pkg::fbep_prot_t set_mode;
	logic [fbep_pkg::REGION_W-1:0] look_region;
	fbep_pkg::fbep_prot_t look_mode;

	modport table_end (
		input set_valid,
		input set_region,
		input set_mode,
		input look_region,
		output look_mode
	);

	modport ctrl_end (
		output set_valid,
		output set_region,
		output set_mode,
		output look_region,
		input look_mode
	);
endinterface : fbep_prot_if

// ---- hw/fbep_prot_table.sv ----
// Per-region protection settings, one entry for each 2 KB region.
// Assumes writes and lookups come from logic on ref_clk.
`timescale 1ns/1ps

module fbep_prot_table (
	input wire logic ref_clk,
	input wire logic rst,
	fbep_prot_if.table_end prot
);

	fbep_pkg::fbep_prot_t mode_ff [fbep_pkg::NUM_REGIONS];

	////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < fbep_pkg::NUM_REGIONS; gi++) begin : g_region
			// Reserved code is ignored so a slip cannot unlock a region
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					mode_ff[gi] <= fbep_pkg::PROT_RESET;
				end else if (prot.set_valid
						&& prot.set_region == fbep_pkg::REGION_W'(gi)
						&& prot.set_mode != fbep_pkg::PROT_RESERVED) begin
					mode_ff[gi] <= prot.set_mode; // [RULE_04] [RULE_05]
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Out-of-range index reads open; the controller refuses those anyway
	always_comb begin
		if (prot.look_region < fbep_pkg::REGION_W'(fbep_pkg::NUM_REGIONS)) begin
			prot.look_mode = mode_ff[prot.look_region];
		end else begin
			prot.look_mode = fbep_pkg::PROT_OPEN;
		end
	end

endmodule : fbep_prot_table

// ---- hw/fbep_top.sv ----
// Erase sequencer and region protection checker for a 96 KB flash array.
// Assumes requesters and the array share ref_clk; array reads take one cycle.
//
// Overview of operation
// RULE_01 - Manage a 96 KB program flash array
// RULE_02 - Erase each 1 KB block on its own
// RULE_03 - Erased block holds all ones
// RULE_04 - Protection set per 2 KB region pair
// RULE_05 - Region may be open, read-only or execute-only
// RULE_06 - Read-only regions refuse erase and program
// RULE_07 - Execute-only regions refuse erase and program
// RULE_08 - Execute-only regions serve instruction fetches only
// RULE_09 - Sticky flag records every protection refusal
`timescale 1ns/1ps

module fbep_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic prot_set_valid,
	input wire logic [fbep_pkg::REGION_W-1:0] prot_set_region,
	input wire fbep_pkg::fbep_prot_t prot_set_mode,
	input wire logic req_valid,
	input wire fbep_pkg::fbep_kind_t req_kind,
	input wire logic req_debug,
	input wire logic [fbep_pkg::ADDR_W-1:0] req_addr,
	input wire logic [fbep_pkg::DATA_W-1:0] req_wdata,
	input wire logic viol_clear,
	input wire logic [fbep_pkg::DATA_W-1:0] arr_rdata,
	output logic req_ready_ff,
	output logic rsp_valid_ff,
	output logic rsp_denied_ff,
	output logic [fbep_pkg::DATA_W-1:0] rsp_rdata_ff,
	output logic viol_flag_ff,
	output logic arr_rd_en_ff,
	output logic arr_wr_en_ff,
	output logic [fbep_pkg::WADDR_W-1:0] arr_addr_ff,
	output logic [fbep_pkg::DATA_W-1:0] arr_wdata_ff
);

	////////////////////////////////////////////////////////////////////////
	// Access decision for one region mode
	function automatic logic access_ok(
		input fbep_pkg::fbep_prot_t mode,
		input fbep_pkg::fbep_kind_t kind,
		input logic debug
	);
		logic ok;
		ok = 1'b1;
		case (mode)
			fbep_pkg::PROT_READ_ONLY: begin
				ok = (kind == fbep_pkg::KIND_FETCH)
					|| (kind == fbep_pkg::KIND_READ); // [RULE_06]
			end
			fbep_pkg::PROT_EXEC_ONLY: begin
				// A debugger never fetches, so its reads are data reads
				ok = (kind == fbep_pkg::KIND_FETCH) && !debug; // [RULE_07] [RULE_08]
			end
			default: begin
				ok = 1'b1;
			end
		endcase
		return ok;
	endfunction : access_ok

	////////////////////////////////////////////////////////////////////////
	fbep_prot_if prot ();

	fbep_prot_table u_table (
		.ref_clk(ref_clk),
		.rst(rst),
		.prot(prot.table_end)
	);

	assign prot.set_valid = prot_set_valid;
	assign prot.set_region = prot_set_region;
	assign prot.set_mode = prot_set_mode;
	assign prot.look_region = req_addr[fbep_pkg::ADDR_W-1:fbep_pkg::REGION_LSB];

	fbep_pkg::fbep_state_t state_ff;
	logic [fbep_pkg::WCNT_W-1:0] wcnt_ff;
	logic [fbep_pkg::BLOCK_W-1:0] erase_blk_ff;
	logic erase_done_ff;
	logic take;
	logic in_range;
	logic allowed;
	logic deny_prot;

	assign take = req_valid && req_ready_ff;
	assign in_range = req_addr < fbep_pkg::FLASH_LIMIT; // [RULE_01]
	assign allowed = access_ok(prot.look_mode, req_kind, req_debug);
	assign deny_prot = take && in_range && !allowed;

	////////////////////////////////////////////////////////////////////////
	// Sequencer state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= fbep_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				fbep_pkg::ST_IDLE: begin
					if (take && in_range && allowed) begin
						if (req_kind == fbep_pkg::KIND_ERASE) begin
							state_ff <= fbep_pkg::ST_ERASE; // [RULE_02]
						end else if (req_kind != fbep_pkg::KIND_PROGRAM) begin
							state_ff <= fbep_pkg::ST_RWAIT;
						end
					end
				end
				fbep_pkg::ST_RWAIT: begin
					state_ff <= fbep_pkg::ST_RCAP;
				end
				fbep_pkg::ST_RCAP: begin
					state_ff <= fbep_pkg::ST_IDLE;
				end
				fbep_pkg::ST_ERASE: begin
					if (wcnt_ff == fbep_pkg::WCNT_LAST) begin
						state_ff <= fbep_pkg::ST_IDLE;
					end
				end
				default: begin
					state_ff <= fbep_pkg::ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Erase walk over the 256 words of one block
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wcnt_ff <= fbep_pkg::WCNT_RESET;
			erase_blk_ff <= '0;
		end else if (state_ff == fbep_pkg::ST_IDLE && take
				&& req_kind == fbep_pkg::KIND_ERASE) begin
			wcnt_ff <= fbep_pkg::WCNT_RESET;
			erase_blk_ff <= req_addr[fbep_pkg::ADDR_W-1:fbep_pkg::BLOCK_LSB];
		end else if (state_ff == fbep_pkg::ST_ERASE) begin
			wcnt_ff <= wcnt_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array port
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arr_rd_en_ff <= 1'b0;
			arr_wr_en_ff <= 1'b0;
			arr_addr_ff <= '0;
			arr_wdata_ff <= '0;
		end else begin
			arr_rd_en_ff <= 1'b0;
			arr_wr_en_ff <= 1'b0;
			if (state_ff == fbep_pkg::ST_ERASE) begin
				// Only words of the chosen block are touched
				arr_wr_en_ff <= 1'b1; // [RULE_02]
				arr_addr_ff <= {erase_blk_ff, wcnt_ff};
				arr_wdata_ff <= fbep_pkg::ERASED_WORD; // [RULE_03]
			end else if (take && in_range && allowed
					&& req_kind != fbep_pkg::KIND_ERASE) begin
				arr_rd_en_ff <= (req_kind != fbep_pkg::KIND_PROGRAM);
				arr_wr_en_ff <= (req_kind == fbep_pkg::KIND_PROGRAM);
				arr_addr_ff <= req_addr[fbep_pkg::ADDR_W-1:fbep_pkg::WORD_LSB];
				arr_wdata_ff <= req_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Answer waits one edge so the array has taken the last word
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			erase_done_ff <= 1'b0;
		end else begin
			erase_done_ff <= (state_ff == fbep_pkg::ST_ERASE)
					&& (wcnt_ff == fbep_pkg::WCNT_LAST); // [RULE_02]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Requester handshake and answer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_ready_ff <= 1'b0;
		end else if (take) begin
			req_ready_ff <= 1'b0;
		end else begin
			// Ready again once the answer has been given
			req_ready_ff <= (state_ff == fbep_pkg::ST_IDLE) && !rsp_valid_ff
					&& !erase_done_ff;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_denied_ff <= 1'b0;
			rsp_rdata_ff <= '0;
		end else begin
			rsp_valid_ff <= 1'b0;
			if (take && (!in_range || !allowed
					|| req_kind == fbep_pkg::KIND_PROGRAM)) begin
				rsp_valid_ff <= 1'b1;
				rsp_denied_ff <= !in_range || !allowed; // [RULE_06] [RULE_07]
				rsp_rdata_ff <= '0; // [RULE_08]
			end else if (state_ff == fbep_pkg::ST_RCAP) begin
				rsp_valid_ff <= 1'b1;
				rsp_denied_ff <= 1'b0;
				rsp_rdata_ff <= arr_rdata;
			end else if (erase_done_ff) begin
				rsp_valid_ff <= 1'b1;
				rsp_denied_ff <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Set beats clear so a refusal in the clearing cycle is kept
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			viol_flag_ff <= 1'b0;
		end else if (deny_prot) begin
			viol_flag_ff <= 1'b1; // [RULE_09]
		end else if (viol_clear) begin
			viol_flag_ff <= 1'b0;
		end
	end

endmodule : fbep_top

// ---- tb/fbep_array_model.sv ----
// Behavioural flash array facing the controller.
// Assumes read data is wanted on the edge after the strobe.
`timescale 1ns/1ps

module fbep_array_model (
	input wire logic ref_clk,
	input wire logic rd_en,
	input wire logic wr_en,
	input wire logic [14:0] addr,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);
	logic [31:0] mem [int];
	// Idle data toggles so a stale word never looks fresh
	always @(posedge ref_clk) begin
		if (wr_en)
			mem[addr] = wdata;
		rdata <= rd_en ? mem[addr] : ~rdata;
	end
endmodule : fbep_array_model

// ---- tb/fbep_top_sva.sv ----
// Checker for the flash erase and protection controller.
// Assumes it sees only top-level ports, all on ref_clk.
`timescale 1ns/1ps

module fbep_top_sva (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire fbep_pkg::fbep_kind_t req_kind,
	input wire logic req_debug,
	input wire logic [16:0] req_addr,
	input wire logic viol_clear,
	input wire logic [31:0] arr_rdata,
	input wire logic req_ready_ff,
	input wire logic rsp_valid_ff,
	input wire logic rsp_denied_ff,
	input wire logic [31:0] rsp_rdata_ff,
	input wire logic viol_flag_ff,
	input wire logic arr_rd_en_ff,
	input wire logic arr_wr_en_ff,
	input wire logic [14:0] arr_addr_ff,
	input wire logic [31:0] arr_wdata_ff
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire take = req_valid & req_ready_ff;
	////////////////////////////////////////////////////////////
	a_fetch_served: assert property (
		take && req_kind == fbep_pkg::KIND_FETCH && !req_debug
		&& req_addr < fbep_pkg::FLASH_LIMIT
		|=> arr_rd_en_ff ##2 rsp_valid_ff && !rsp_denied_ff)
		else $error("fetch not served");
	a_read_data: assert property (
		rsp_valid_ff && !rsp_denied_ff && $past(arr_rd_en_ff, 2)
		|-> rsp_rdata_ff == $past(arr_rdata))
		else $error("read data not passed on");
	a_out_range: assert property (
		take && req_addr >= fbep_pkg::FLASH_LIMIT
		|=> rsp_valid_ff && rsp_denied_ff && !arr_rd_en_ff)
		else $error("address past array not refused");
	a_deny_quiet: assert property (
		rsp_valid_ff && rsp_denied_ff
		|-> !arr_wr_en_ff && rsp_rdata_ff == 32'h0)
		else $error("refused access touched data");
	a_flag_set: assert property (
		rsp_valid_ff && rsp_denied_ff
		&& $past(req_addr) < fbep_pkg::FLASH_LIMIT |-> viol_flag_ff)
		else $error("refusal left flag clear");
	a_flag_sticky: assert property (
		viol_flag_ff && !viol_clear |=> viol_flag_ff)
		else $error("flag dropped without clear");
	a_erase_ones: assert property (
		arr_wr_en_ff && $past(arr_wr_en_ff)
		|-> arr_wdata_ff == fbep_pkg::ERASED_WORD)
		else $error("erase word not all ones");
	a_erase_end: assert property (
		arr_wr_en_ff && $past(arr_wr_en_ff) && arr_addr_ff[7:0] == 8'hFF
		|=> !arr_wr_en_ff && rsp_valid_ff && !rsp_denied_ff)
		else $error("erase did not end at block top");
endmodule : fbep_top_sva

bind fbep_top fbep_top_sva u_sva (.ref_clk, .rst, .req_valid, .req_kind,
	.req_debug, .req_addr, .viol_clear, .arr_rdata, .req_ready_ff,
	.rsp_valid_ff, .rsp_denied_ff, .rsp_rdata_ff, .viol_flag_ff,
	.arr_rd_en_ff, .arr_wr_en_ff, .arr_addr_ff, .arr_wdata_ff);

// ---- tb/tb_fbep_top.sv ----
// Self-checking bench for the flash erase and protection controller.
// Assumes the behavioural array model on the far side.
`timescale 1ns/1ps

module tb_fbep_top;
	typedef struct {
		logic den;
		logic rd;
		logic [31:0] data;
	} fbep_note_t;
	logic ref_clk, rst, prot_set_valid, req_valid, req_debug, viol_clear;
	logic req_ready_ff, rsp_valid_ff, rsp_denied_ff, viol_flag_ff;
	logic arr_rd_en_ff, arr_wr_en_ff;
	logic [5:0] prot_set_region;
	logic [16:0] req_addr;
	logic [14:0] arr_addr_ff;
	logic [31:0] req_wdata, arr_rdata, rsp_rdata_ff, arr_wdata_ff, d0, d1;
	logic [15:0] lfsr;
	fbep_pkg::fbep_prot_t prot_set_mode;
	fbep_pkg::fbep_kind_t req_kind;
	fbep_note_t notes [$];
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;

	fbep_top u_dut (.ref_clk(ref_clk), .rst(rst),
		.prot_set_valid(prot_set_valid), .prot_set_region(prot_set_region),
		.prot_set_mode(prot_set_mode), .req_valid(req_valid),
		.req_kind(req_kind), .req_debug(req_debug), .req_addr(req_addr),
		.req_wdata(req_wdata), .viol_clear(viol_clear),
		.arr_rdata(arr_rdata), .req_ready_ff(req_ready_ff),
		.rsp_valid_ff(rsp_valid_ff), .rsp_denied_ff(rsp_denied_ff),
		.rsp_rdata_ff(rsp_rdata_ff), .viol_flag_ff(viol_flag_ff),
		.arr_rd_en_ff(arr_rd_en_ff), .arr_wr_en_ff(arr_wr_en_ff),
		.arr_addr_ff(arr_addr_ff), .arr_wdata_ff(arr_wdata_ff));
	fbep_array_model u_arr (.ref_clk, .rd_en(arr_rd_en_ff),
		.wr_en(arr_wr_en_ff), .addr(arr_addr_ff), .wdata(arr_wdata_ff),
		.rdata(arr_rdata));

	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr_next(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr_next

	task automatic fail(string msg);
		fail_count++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask : fail

	task automatic chk_rsp(fbep_note_t n);
		checked++;
		if (rsp_denied_ff !== n.den || (n.rd && rsp_rdata_ff !== n.data))
			fail("response mismatch");
	endtask : chk_rsp

	task automatic chk_flag(logic exp);
		checked++;
		if (viol_flag_ff !== exp)
			fail("violation flag mismatch");
	endtask : chk_flag

	task automatic end_of_test;
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	// Held until taken; the global cycle ceiling bounds every wait
	task automatic req(logic [1:0] k, logic dbg, logic [16:0] a,
		logic [31:0] d, logic den);
		notes.push_back('{den, den | ~k[1], den ? 32'h0 : d});
		@(negedge ref_clk);
		{req_valid, req_debug, req_addr, req_wdata} = {1'h1, dbg, a, d};
		req_kind = fbep_pkg::fbep_kind_t'(k);
		do
			@(posedge ref_clk);
		while (req_ready_ff !== 1'h1);
		@(negedge ref_clk);
		req_valid = 1'h0;
		wait (notes.size() == 0);
	endtask : req

	task automatic ctl(logic [1:0] m, logic c);
		@(negedge ref_clk);
		{prot_set_valid, viol_clear} = {1'h1, c};
		prot_set_mode = fbep_pkg::fbep_prot_t'(m);
		@(negedge ref_clk);
		{prot_set_valid, viol_clear} = 2'h0;
	endtask : ctl

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles > 3000) begin
			fail("timeout");
			end_of_test();
		end else if (rsp_valid_ff === 1'h1)
			chk_rsp(notes.pop_front());
	end

	initial begin
		{rst, prot_set_valid, req_valid, req_debug, viol_clear} = 5'h10;
		{prot_set_region, req_addr, req_wdata} = {6'h02, 17'h0, 32'h0};
		prot_set_mode = fbep_pkg::PROT_OPEN;
		req_kind = fbep_pkg::KIND_FETCH;
		lfsr = lfsr_next(16'h24C1);
		d0 = {lfsr, ~lfsr};
		lfsr = lfsr_next(lfsr);
		d1 = {~lfsr, lfsr};
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'h0;
		req(2'h2, 1'h0, 17'h01004, d0, 1'h0);
		req(2'h2, 1'h0, 17'h01400, d1, 1'h0);
		req(2'h3, 1'h0, 17'h013FC, d0, 1'h0);
		req(2'h1, 1'h0, 17'h01004, 32'hFFFFFFFF, 1'h0);
		req(2'h1, 1'h0, 17'h01400, d1, 1'h0);
		ctl(2'h1, 1'h0);
		req(2'h3, 1'h0, 17'h01400, d0, 1'h1);
		req(2'h2, 1'h0, 17'h01404, d0, 1'h1);
		chk_flag(1'h1);
		req(2'h1, 1'h1, 17'h01400, d1, 1'h0);
		ctl(2'h2, 1'h1);
		chk_flag(1'h0);
		req(2'h0, 1'h0, 17'h01400, d1, 1'h0);
		req(2'h1, 1'h0, 17'h01400, d1, 1'h1);
		req(2'h0, 1'h1, 17'h01400, d1, 1'h1);
		req(2'h3, 1'h0, 17'h017FC, d0, 1'h1);
		chk_flag(1'h1);
		req(2'h2, 1'h0, 17'h01800, d0, 1'h0);
		req(2'h0, 1'h0, 17'h01800, d0, 1'h0);
		req(2'h2, 1'h0, 17'h17FFC, d1, 1'h0);
		req(2'h1, 1'h0, 17'h18000, d1, 1'h1);
		ctl(2'h3, 1'h0);
		req(2'h1, 1'h0, 17'h01400, d1, 1'h1);
		@(negedge ref_clk);
		rst = 1'h1;
		repeat (2) @(negedge ref_clk);
		rst = 1'h0;
		chk_flag(1'h0);
		req(2'h1, 1'h0, 17'h01400, d1, 1'h0);
		end_of_test();
	end
endmodule : tb_fbep_top
